// ==== verilog/sxs_alu_consts.vh ====
// Constants for the subtract, direction load, xor and swap execution datapath.
`ifndef SXS_ALU_CONSTS_VH
`define SXS_ALU_CONSTS_VH

// ----------------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------------
`define SXS_OFS_INSTR    8'h00
`define SXS_OFS_ACC      8'h04
`define SXS_OFS_STATUS   8'h08
`define SXS_OFS_DIR5     8'h0C
`define SXS_OFS_DIR6     8'h10
`define SXS_OFS_FADDR    8'h14
`define SXS_OFS_FDATA    8'h18
`define SXS_OFS_RETIRED  8'h1C

// ----------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------
`define SXS_ST_CARRY     0
`define SXS_ST_DCARRY    1
`define SXS_ST_ZERO      2
`define SXS_ST_ILLEGAL   3
`define SXS_ST_BUSY      7

// ----------------------------------------------------------------------
// Opcode fields and patterns
// ----------------------------------------------------------------------
`define SXS_OP_DEST      7
`define SXS_OP_SUB       6'h02
`define SXS_OP_SWAP      6'h0E
`define SXS_OP_XORL      6'h3A
`define SXS_OP_LDIR      11'h00C
`define SXS_DIR_SEL_LO   3'h5
`define SXS_DIR_SEL_HI   3'h6

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define SXS_RST_ACC      8'h00
`define SXS_RST_DIR      8'hFF
`define SXS_RST_INSTR    14'h0000
`define SXS_OSC_PER_CYC  4

`endif

// ==== verilog/sxs_file_ram.v ====
// File register array with one write port and two read ports.
`timescale 1ns/1ns
`default_nettype none

module sxs_file_ram
#(
  parameter AW = 7,
  parameter DW = 8
)
(
  input  wire          mclk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr_a,
  output wire [DW-1:0] rdata_a,
  input  wire [AW-1:0] raddr_b,
  output wire [DW-1:0] rdata_b
);

  // Contents are undefined after reset, as in the core's data memory.
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge mclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule // sxs_file_ram

`default_nettype wire

// ==== verilog/sxs_alu.v ====
// Execution datapath for subtract, direction load, xor and swap opcodes.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "sxs_alu_consts.vh"

// Contract
// - Subtract-from-file computes file minus accumulator in two's complement and updates carry, digit carry and zero.
// - Subtract-from-file sends its result to the accumulator when the destination bit is 0 and to the file register when 1.
// - After a subtraction carry is 1 for a result that is positive or zero and 0 when a borrow occurred.
// - Load-direction copies the accumulator into direction register 5 or 6 only, changing no flag.
// - Load-direction is decoded from all-zero upper bits, then 0110, a zero bit and a three-bit register field.
// - Load-direction is one program word executed in one instruction cycle.
// - Xor-literal xors the accumulator with the low eight opcode bits into the accumulator, changing only zero.
// - Swap-nibbles moves file bits 3 to 0 into result bits 7 to 4 and bits 7 to 4 into bits 3 to 0.
// - Swap-nibbles places its result in the accumulator for destination 0 and the file register for 1, changing no flag.
// - Each instruction cycle lasts four clock periods.
module sxs_alu
#(
  parameter AW = 7
)
(
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  output wire [7:0]  dir5_out,
  output wire [7:0]  dir6_out,
  output wire        busy
);

  // --------------------------------------------------------------------
  // Instruction cycle phases
  // --------------------------------------------------------------------
  localparam [4:0] PH_IDLE = 5'h01;
  localparam [4:0] PH_Q1   = 5'h02;
  localparam [4:0] PH_Q2   = 5'h04;
  localparam [4:0] PH_Q3   = 5'h08;
  localparam [4:0] PH_Q4   = 5'h10;

  localparam [2:0] K_NONE = 3'h0;
  localparam [2:0] K_SUB  = 3'h1;
  localparam [2:0] K_LDIR = 3'h2;
  localparam [2:0] K_XORL = 3'h3;
  localparam [2:0] K_SWAP = 3'h4;

  reg  [4:0]    phase_q;
  reg  [4:0]    phase_d;
  reg  [13:0]   instr_q;
  reg  [7:0]    acc_q;
  reg  [7:0]    dir5_q;
  reg  [7:0]    dir6_q;
  reg  [AW-1:0] faddr_q;
  reg  [7:0]    opnd_q;
  reg           carry_q;
  reg           dcarry_q;
  reg           zero_q;
  reg           illegal_q;
  reg  [15:0]   retired_q;

  wire [7:0]    ram_rd_core;
  wire [7:0]    ram_rd_bus;
  wire [2:0]    kind;
  wire          dest_file;

  // --------------------------------------------------------------------
  // Decode and arithmetic
  // --------------------------------------------------------------------
  function [2:0] op_kind;
    input [13:0] op;
    begin
      if (op[13:8] == `SXS_OP_SUB)
        op_kind = K_SUB;
      else if (op[13:8] == `SXS_OP_SWAP)
        op_kind = K_SWAP;
      else if (op[13:8] == `SXS_OP_XORL)
        op_kind = K_XORL;
      else if ((op[13:3] == `SXS_OP_LDIR) &&
               ((op[2:0] == `SXS_DIR_SEL_LO) ||
                (op[2:0] == `SXS_DIR_SEL_HI)))
        op_kind = K_LDIR;
      else
        op_kind = K_NONE;
    end
  endfunction

  // Bit 8 is the carry out of f + ~w + 1, so it is 1 when no borrow.
  function [8:0] sub_carry;
    input [7:0] a;
    input [7:0] b;
    begin
      sub_carry = {1'b0, a} + {1'b0, ~b} + 9'h001;
    end
  endfunction

  function [4:0] sub_nib;
    input [3:0] a;
    input [3:0] b;
    begin
      sub_nib = {1'b0, a} + {1'b0, ~b} + 5'h01;
    end
  endfunction

  assign kind      = op_kind(instr_q);
  assign dest_file = instr_q[`SXS_OP_DEST];

  // --------------------------------------------------------------------
  // Result computation for the instruction in flight
  // --------------------------------------------------------------------
  reg  [7:0] res;
  reg        res_to_acc;
  reg        res_to_file;
  reg        upd_cdc;
  reg        upd_z;
  reg        res_c;
  reg        res_dc;
  reg  [8:0] full_diff;
  reg  [4:0] nib_diff;

  always @*
  begin
    full_diff   = sub_carry(opnd_q, acc_q);
    nib_diff    = sub_nib(opnd_q[3:0], acc_q[3:0]);
    res         = 8'h00;
    res_to_acc  = 1'b0;
    res_to_file = 1'b0;
    upd_cdc     = 1'b0;
    upd_z       = 1'b0;
    res_c       = full_diff[8];
    res_dc      = nib_diff[4];
    case (kind)
      K_SUB:
      begin
        res         = full_diff[7:0];
        res_to_acc  = ~dest_file;
        res_to_file = dest_file;
        upd_cdc     = 1'b1;
        upd_z       = 1'b1;
      end
      K_XORL:
      begin
        res        = acc_q ^ instr_q[7:0];
        res_to_acc = 1'b1;
        upd_z      = 1'b1;
      end
      K_SWAP:
      begin
        res         = {opnd_q[3:0], opnd_q[7:4]};
        res_to_acc  = ~dest_file;
        res_to_file = dest_file;
      end
      default:
      begin
        res = acc_q;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Instruction cycle sequencer
  // --------------------------------------------------------------------
  wire setup   = psel & ~penable;
  wire wr_take = psel & penable & pwrite;
  wire rd_take = psel & penable & ~pwrite;
  wire in_q4   = (phase_q == PH_Q4);
  wire idle    = (phase_q == PH_IDLE);
  wire start   = wr_take & idle & ~pslverr & (paddr == `SXS_OFS_INSTR);

  // Four clock periods make one instruction cycle, Q1 to Q4.
  always @*
  begin
    case (phase_q)
      PH_IDLE: phase_d = start ? PH_Q1 : PH_IDLE;
      PH_Q1:   phase_d = PH_Q2;
      PH_Q2:   phase_d = PH_Q3;
      PH_Q3:   phase_d = PH_Q4;
      PH_Q4:   phase_d = PH_IDLE;
      default: phase_d = PH_IDLE;
    endcase
  end

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      phase_q <= PH_IDLE;
    else
      phase_q <= phase_d;
  end

  // The operand is captured in Q1 so the file write in Q4 cannot race it.
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      opnd_q <= 8'h00;
    else if (phase_q == PH_Q1)
      opnd_q <= ram_rd_core;
  end

  // --------------------------------------------------------------------
  // Architectural state
  // --------------------------------------------------------------------
  // A write whose setup saw busy was answered with an error and is dropped
  // even if busy falls before its access edge, so the Q4 commit never
  // competes with software for a register.
  wire sw_wr = wr_take & idle & ~pslverr;
  wire bad_op = in_q4 & (kind == K_NONE);

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      instr_q   <= `SXS_RST_INSTR;
      acc_q     <= `SXS_RST_ACC;
      dir5_q    <= `SXS_RST_DIR;
      dir6_q    <= `SXS_RST_DIR;
      faddr_q   <= {AW{1'b0}};
      carry_q   <= 1'b0;
      dcarry_q  <= 1'b0;
      zero_q    <= 1'b0;
      illegal_q <= 1'b0;
      retired_q <= 16'h0000;
    end
    else
    begin
      if (start)
        instr_q <= pwdata[13:0];
      if (in_q4)
      begin
        retired_q <= retired_q + 16'h0001;
        if (res_to_acc)
          acc_q <= res;
        if (upd_cdc)
        begin
          carry_q  <= res_c;
          dcarry_q <= res_dc;
        end
        if (upd_z)
          zero_q <= (res == 8'h00);
        if ((kind == K_LDIR) && (instr_q[2:0] == `SXS_DIR_SEL_LO))
          dir5_q <= acc_q;
        if ((kind == K_LDIR) && (instr_q[2:0] == `SXS_DIR_SEL_HI))
          dir6_q <= acc_q;
      end
      if (sw_wr)
      begin
        case (paddr)
          `SXS_OFS_ACC:   acc_q   <= pwdata[7:0];
          `SXS_OFS_DIR5:  dir5_q  <= pwdata[7:0];
          `SXS_OFS_DIR6:  dir6_q  <= pwdata[7:0];
          `SXS_OFS_FADDR: faddr_q <= pwdata[AW-1:0];
          `SXS_OFS_STATUS:
          begin
            carry_q  <= pwdata[`SXS_ST_CARRY];
            dcarry_q <= pwdata[`SXS_ST_DCARRY];
            zero_q   <= pwdata[`SXS_ST_ZERO];
          end
          default: ;
        endcase
      end
      // Writing 1 clears the illegal flag; a new detection wins.
      if (bad_op)
        illegal_q <= 1'b1;
      else if (sw_wr && (paddr == `SXS_OFS_STATUS) &&
               pwdata[`SXS_ST_ILLEGAL])
        illegal_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // File register array
  // --------------------------------------------------------------------
  wire          ram_we;
  wire [AW-1:0] ram_waddr;
  wire [7:0]    ram_wdata;

  assign ram_we    = (in_q4 & res_to_file) |
                     (sw_wr & (paddr == `SXS_OFS_FDATA));
  assign ram_waddr = in_q4 ? instr_q[AW-1:0] : faddr_q;
  assign ram_wdata = in_q4 ? res : pwdata[7:0];

  sxs_file_ram #(
    .AW (AW),
    .DW (8)
  ) u_ram (
    .mclk    (mclk),
    .we      (ram_we),
    .waddr   (ram_waddr),
    .wdata   (ram_wdata),
    .raddr_a (instr_q[AW-1:0]),
    .rdata_a (ram_rd_core),
    .raddr_b (faddr_q),
    .rdata_b (ram_rd_bus)
  );

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  function known_ofs;
    input [7:0] a;
    begin
      known_ofs = (a == `SXS_OFS_INSTR)  || (a == `SXS_OFS_ACC)   ||
                  (a == `SXS_OFS_STATUS) || (a == `SXS_OFS_DIR5)  ||
                  (a == `SXS_OFS_DIR6)   || (a == `SXS_OFS_FADDR) ||
                  (a == `SXS_OFS_FDATA)  || (a == `SXS_OFS_RETIRED);
    end
  endfunction

  reg [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h00000000;
    case (paddr)
      `SXS_OFS_INSTR:   rd_mux = {18'h00000, instr_q};
      `SXS_OFS_ACC:     rd_mux = {24'h000000, acc_q};
      `SXS_OFS_STATUS:  rd_mux = {24'h000000, ~idle, 3'h0, illegal_q,
                                  zero_q, dcarry_q, carry_q};
      `SXS_OFS_DIR5:    rd_mux = {24'h000000, dir5_q};
      `SXS_OFS_DIR6:    rd_mux = {24'h000000, dir6_q};
      `SXS_OFS_FADDR:   rd_mux = {{(32-AW){1'b0}}, faddr_q};
      `SXS_OFS_FDATA:   rd_mux = {24'h000000, ram_rd_bus};
      `SXS_OFS_RETIRED: rd_mux = {16'h0000, retired_q};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // Read data and error are registered in setup, so every access ends
  // after exactly one access cycle.
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~known_ofs(paddr) | (pwrite & ~idle) |
                 (pwrite & (paddr == `SXS_OFS_RETIRED));
    end
    else if (rd_take | wr_take)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  assign pready   = 1'b1;
  assign dir5_out = dir5_q;
  assign dir6_out = dir6_q;
  assign busy     = ~idle;

endmodule // sxs_alu

`default_nettype wire

// ==== verif/sxs_alu_properties.sv ====
// Port-level assertions for the execution datapath.
`timescale 1ns/1ns
`default_nettype none
`include "sxs_alu_consts.vh"

module sxs_alu_chk
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [7:0]  dir5_out,
  input wire logic [7:0]  dir6_out,
  input wire logic        busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire logic wr_acc = psel && penable && pwrite;
  wire logic rd_acc = psel && penable && !pwrite;

  property p_ready; pready; endproperty
  a_ready: assert property (p_ready)
    else $error("pready dropped");
  // A start is taken only when busy was low at both setup and access.
  property p_busy_len;
    wr_acc && paddr == `SXS_OFS_INSTR && !busy && !$past(busy)
      |=> busy [*4] ##1 !busy;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("instruction cycle not four clocks");
  property p_busy_cause;
    $rose(busy) |-> $past(wr_acc && paddr == `SXS_OFS_INSTR);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without a start");
  property p_busy_max; busy [*4] |=> !busy; endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy longer than four clocks");
  property p_dir5_hold;
    $changed(dir5_out) |->
      $fell(busy) || $past(wr_acc && paddr == `SXS_OFS_DIR5);
  endproperty
  a_dir5_hold: assert property (p_dir5_hold)
    else $error("dir5 changed without cause");
  property p_dir6_hold;
    $changed(dir6_out) |->
      $fell(busy) || $past(wr_acc && paddr == `SXS_OFS_DIR6);
  endproperty
  a_dir6_hold: assert property (p_dir6_hold)
    else $error("dir6 changed without cause");
  property p_rd_dir5;
    rd_acc && paddr == `SXS_OFS_DIR5 && $stable(dir5_out)
      |-> prdata == {24'h000000, dir5_out};
  endproperty
  a_rd_dir5: assert property (p_rd_dir5)
    else $error("dir5 readback differs from port");
  property p_rd_busy;
    rd_acc && paddr == `SXS_OFS_STATUS |-> prdata[`SXS_ST_BUSY] == $past(busy);
  endproperty
  a_rd_busy: assert property (p_rd_busy)
    else $error("status busy bit differs from port");
endmodule // sxs_alu_chk

bind sxs_alu sxs_alu_chk u_chk (.mclk(mclk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .dir5_out(dir5_out), .dir6_out(dir6_out), .busy(busy));
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench with a reference model of the four opcodes.
`timescale 1ns/1ns
`default_nettype none
`include "sxs_alu_consts.vh"

module testbench;
  logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr, busy;
  logic [7:0]  paddr, dir5_out, dir6_out, a, fv, k, r, d5, d6;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] op;
  logic [6:0]  f;
  logic        d, err, c, dc, z, ill;
  int          errors, cmp_count, seed, kind, dsel, i, n;

  sxs_alu #(.AW(7)) u_sxs_alu (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .dir5_out(dir5_out), .dir6_out(dir6_out), .busy(busy));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic conclude();
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ev, got);
    cmp_count++;
    if (got !== ev)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ev, got);
    end
  endtask

  // An idle edge precedes every setup so no strobe is driven twice at once.
  task automatic bus(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd);
    int w;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= ad; pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    w = 0;
    do
    begin
      @(posedge mclk);
      w++;
    end
    while (pready !== 1'b1 && w < 50);
    if (pready !== 1'b1)
    begin
      errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial
  begin
    seed = 3526;
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    d5 = `SXS_RST_DIR;
    d6 = `SXS_RST_DIR;
    bus(0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    for (i = 0; i < 200; i++)
    begin
      kind = $unsigned($random(seed)) % 4;
      {f, d} = 8'($random(seed));
      a = 8'($random(seed));
      fv = (($random(seed) & 3) == 0) ? a : 8'($random(seed));
      k = (($random(seed) & 3) == 0) ? a : 8'($random(seed));
      {z, dc, c} = 3'($random(seed));
      ill = 1'b0;
      bus(1, `SXS_OFS_ACC, {24'h0, a});
      bus(1, `SXS_OFS_FADDR, {25'h0, f});
      bus(1, `SXS_OFS_FDATA, {24'h0, fv});
      bus(1, `SXS_OFS_STATUS, {28'h0, 1'b1, z, dc, c});
      case (kind)
        0:
        begin
          op = {`SXS_OP_SUB, d, f};
          r = fv - a;
          c = fv >= a;
          dc = fv[3:0] >= a[3:0];
          z = r == 8'h00;
          if (d) fv = r; else a = r;
        end
        1:
        begin
          op = {`SXS_OP_XORL, k};
          a = a ^ k;
          z = a == 8'h00;
        end
        2:
        begin
          op = {`SXS_OP_SWAP, d, f};
          r = {fv[3:0], fv[7:4]};
          if (d) fv = r; else a = r;
        end
        default:
        begin
          dsel = 5 + $unsigned($random(seed)) % 3;
          op = {`SXS_OP_LDIR, 3'(dsel)};
          if (dsel == 5) d5 = a;
          if (dsel == 6) d6 = a;
          ill = (dsel == 7);
        end
      endcase
      bus(1, `SXS_OFS_INSTR, {18'h0, op});
      // A write while the instruction runs must be refused and not land.
      bus(1, `SXS_OFS_ACC, {24'h0, ~a});
      chk("busy_wr_err", 32'h1, {31'h0, err});
      n = 0;
      do
      begin
        bus(0, `SXS_OFS_STATUS, 32'h0);
        n++;
      end
      while (rd[`SXS_ST_BUSY] !== 1'b0 && n < 10);
      if (rd[`SXS_ST_BUSY] !== 1'b0)
      begin
        errors++;
        conclude();
      end
      chk("flags", {28'h0, ill, z, dc, c}, rd & 32'hF);
      bus(0, `SXS_OFS_ACC, 32'h0);
      chk("acc", {24'h0, a}, rd);
      bus(0, `SXS_OFS_FDATA, 32'h0);
      chk("file", {24'h0, fv}, rd);
      chk("dir5", {24'h0, d5}, {24'h0, dir5_out});
      chk("dir6", {24'h0, d6}, {24'h0, dir6_out});
      bus(0, `SXS_OFS_DIR5, 32'h0);
      chk("dir5_rd", {24'h0, d5}, rd);
      bus(0, `SXS_OFS_DIR6, 32'h0);
      chk("dir6_rd", {24'h0, d6}, rd);
    end
    bus(0, `SXS_OFS_RETIRED, 32'h0);
    chk("retired", 32'h000000C8, rd);
    conclude();
  end
endmodule // testbench
`default_nettype wire
